// ---- shared/pll_pkg.sv ----
// Shared constants and types for the synthesizer divider and lock control
package pll_pkg;
  // Clock rate and the phase window that the lock detector accepts
  localparam int unsigned CLOCK_PERIOD_NS = 10;
  localparam int unsigned PHASE_WINDOW_NS = 250;
  // A longest time rounds down to whole cycles
  localparam int unsigned WINDOW_CYCLES = PHASE_WINDOW_NS / CLOCK_PERIOD_NS;

  localparam int unsigned ERR_W = 6;
  localparam logic [ERR_W-1:0] WINDOW_COUNT = ERR_W'(WINDOW_CYCLES);
  localparam logic [ERR_W-1:0] ERR_RESET = 6'h00;
  localparam logic [ERR_W-1:0] ERR_FIRST = 6'h01;

  // Fixed local-oscillator ratio, 2464
  localparam logic [11:0] LO_RATIO = 12'h9a0;
  localparam logic [11:0] LO_RESET = 12'h000;

  // Reference ratios, 7 bits wide
  localparam logic [6:0] REF_RESET = 7'h00;
  localparam logic [6:0] RATIO_36 = 7'h24;
  localparam logic [6:0] RATIO_33 = 7'h21;
  localparam logic [6:0] RATIO_48 = 7'h30;
  localparam logic [6:0] RATIO_65 = 7'h41;
  localparam logic [6:0] RATIO_63 = 7'h3f;
  localparam logic [6:0] RATIO_64 = 7'h40;
  localparam logic [6:0] RATIO_35 = 7'h23;
  localparam logic [6:0] RATIO_32 = 7'h20;
  localparam logic [6:0] RATIO_49 = 7'h31;

  // Good comparisons needed before lock
  localparam logic [2:0] LOCK_COUNT = 3'h7;
  localparam logic [2:0] GOOD_RESET = 3'h0;

  // Three-state select pin as seen by the pin receiver
  typedef enum logic [1:0] {
    LEVEL_LOW  = 2'b00,
    LEVEL_OPEN = 2'b01,
    LEVEL_HIGH = 2'b10
  } tri_level_t;

  // Four-state loop control pin
  typedef enum logic [1:0] {
    LOOP_GND    = 2'b00,
    LOOP_SUPPLY = 2'b01,
    LOOP_HALF   = 2'b10,
    LOOP_OPEN   = 2'b11
  } loop_level_t;

  typedef enum logic [1:0] {
    PUMP_OFF   = 2'b00,
    PUMP_200UA = 2'b01,
    PUMP_300UA = 2'b10
  } pump_current_t;

  typedef enum logic [1:0] {
    PFD_IDLE   = 2'b00,
    PFD_SOURCE = 2'b01,
    PFD_SINK   = 2'b10
  } pfd_state_t;

  typedef struct packed {
    tri_level_t first;
    tri_level_t second;
  } ref_select_t;

  typedef struct packed {
    logic          source;
    logic          sink;
    pump_current_t current;
  } pump_t;
endpackage

// ---- test/pll_divider_lock_control_test.sv ----
// Self-checking bench for the synthesizer dividers, pump and lock detector
`timescale 1ns/1ns
`default_nettype none
module pll_divider_lock_control_test;
  logic                 i_clock;
  logic                 i_rst;
  logic                 ref_in;
  logic                 vco_in;
  logic                 fast;
  logic                 stall;
  pll_pkg::ref_select_t sel;
  pll_pkg::loop_level_t ctl;
  pll_pkg::pump_t       pump;
  logic                 gnd_node;
  logic                 test_out;
  logic                 lock;
  logic                 lock_oe;
  int                   num_errors = 0;
  int                   total_checks = 0;
  int                   w;
  int                   p;
  logic                 s;
  pll_pkg::tri_level_t  lv_f [3] = '{pll_pkg::LEVEL_LOW, pll_pkg::LEVEL_OPEN, pll_pkg::LEVEL_HIGH};
  pll_pkg::tri_level_t  lv_s [3] = '{pll_pkg::LEVEL_OPEN, pll_pkg::LEVEL_HIGH, pll_pkg::LEVEL_LOW};
  int                   ratio_tab [9] = '{36, 33, 48, 65, 63, 64, 35, 32, 49};

  pll_divider_lock_control dut (
    .i_clock(i_clock), .i_rst(i_rst), .i_reference_input(ref_in), .i_vco_input(vco_in),
    .i_ref_select(sel), .i_loop_control_pin(ctl), .o_pump_output(pump),
    .o_loop_amp_node_ground(gnd_node), .o_test_monitor_output(test_out),
    .o_lock_indicator(lock), .o_lock_indicator_oe(lock_oe));

  pll_ref_vco_model model (
    .i_clock(i_clock), .i_rst(i_rst), .i_fast(fast), .i_vco_stall(stall),
    .o_reference_input(ref_in), .o_vco_input(vco_in));

  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %0d seen %0d", name, exp, got);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Cycles from one rising edge of the monitor pin to the next
  task automatic test_period(output int per);
    logic prev;
    int   n;
    n = 0;
    prev = test_out;
    @(negedge i_clock);
    while (!(prev === 1'b0 && test_out === 1'b1) && n < 10000) begin
      prev = test_out;
      @(negedge i_clock);
      n++;
    end
    per = 0;
    do begin
      prev = test_out;
      @(negedge i_clock);
      per++;
    end while (!(prev === 1'b0 && test_out === 1'b1) && per < 10000);
  endtask

  // Waits for the next pump pulse and returns its width and direction
  task automatic pulse(output int wid, output logic src);
    int n;
    n = 0;
    wid = 0;
    while (pump.source !== 1'b1 && pump.sink !== 1'b1 && n < 6000) begin
      @(negedge i_clock);
      n++;
    end
    src = pump.source;
    while ((pump.source === 1'b1 || pump.sink === 1'b1) && wid < 6000) begin
      @(negedge i_clock);
      wid++;
    end
  endtask

  task automatic lock_seq;
    for (int k = 1; k <= 7; k++) begin
      pulse(w, s);
      chk("pump source", 1, s);
      chk("phase in window", 1, 32'(w > 0 && w < 25));
      chk("lock pulldown", 32'(k < 7), lock_oe);
    end
  endtask

  initial begin
    i_rst = 1'b1;
    fast = 1'b1;
    stall = 1'b0;
    ctl = pll_pkg::LOOP_OPEN;
    sel = '{first: pll_pkg::LEVEL_OPEN, second: pll_pkg::LEVEL_OPEN};
    repeat (3) @(posedge i_clock);
    i_rst <= 1'b0;
    cyc_chk_open: begin
      repeat (3) @(negedge i_clock);
      chk("amp node ground", 1, gnd_node);
      chk("pump current", pll_pkg::PUMP_OFF, pump.current);
      chk("lock pulldown", 1, lock_oe);
      chk("lock data", 0, lock);
    end
    for (int i = 0; i < 9; i++) begin
      @(posedge i_clock);
      sel <= '{first: lv_f[i / 3], second: lv_s[i % 3]};
      test_period(p);
      test_period(p);
      chk("reference ratio", 32'(2 * ratio_tab[i]), p);
    end
    $display("reference ratio test done");
    // Second reset with the slow reference that matches the LO rate
    @(posedge i_clock);
    i_rst <= 1'b1;
    fast <= 1'b0;
    ctl <= pll_pkg::LOOP_GND;
    sel <= '{first: pll_pkg::LEVEL_OPEN, second: pll_pkg::LEVEL_LOW};
    repeat (3) @(posedge i_clock);
    i_rst <= 1'b0;
    repeat (3) @(negedge i_clock);
    chk("pump current", pll_pkg::PUMP_200UA, pump.current);
    chk("amp node ground", 0, gnd_node);
    chk("test monitor", 0, test_out);
    lock_seq();
    $display("lock test done");
    @(posedge i_clock);
    ctl <= pll_pkg::LOOP_SUPPLY;
    repeat (3) @(negedge i_clock);
    chk("pump current", pll_pkg::PUMP_300UA, pump.current);
    chk("lock pulldown", 0, lock_oe);
    @(posedge i_clock);
    ctl <= pll_pkg::LOOP_HALF;
    repeat (3) @(negedge i_clock);
    chk("pump current", pll_pkg::PUMP_OFF, pump.current);
    chk("lock pulldown", 1, lock_oe);
    chk("amp node ground", 0, gnd_node);
    test_period(p);
    chk("LO ratio", 32'(2 * 2464), p);
    @(posedge i_clock);
    ctl <= pll_pkg::LOOP_GND;
    lock_seq();
    $display("control pin test done");
    @(posedge i_clock);
    stall <= 1'b1;
    repeat (60) @(posedge i_clock);
    stall <= 1'b0;
    pulse(w, s);
    chk("pump source", 1, s);
    chk("phase outside window", 1, 32'(w >= 25));
    chk("lock pulldown", 1, lock_oe);
    // One step up in the reference ratio makes the reference lag
    @(posedge i_clock);
    sel <= '{first: pll_pkg::LEVEL_OPEN, second: pll_pkg::LEVEL_OPEN};
    pulse(w, s);
    chk("pump source", 0, s);
    chk("lock pulldown", 1, lock_oe);
    $display("unlock test done");
    report_and_stop();
  end

  initial begin
    // About 18 LO periods of 4928 cycles plus the ratio sweep
    repeat (100000) @(posedge i_clock);
    num_errors++;
    $display("Error watchdog expected end of tests seen timeout");
    report_and_stop();
  end
endmodule
`default_nettype wire

// ---- test/pll_ref_vco_model.sv ----
// Reference oscillator and VCO stand-ins that drive the divider inputs
`timescale 1ns/1ns
`default_nettype none
module pll_ref_vco_model #(
  parameter int REF_PERIOD = 77,
  parameter int REF_START  = 68
) (
  input  wire logic i_clock,
  input  wire logic i_rst,
  input  wire logic i_fast,
  input  wire logic i_vco_stall,
  output var  logic o_reference_input,
  output var  logic o_vco_input
);
  int ref_cnt;
  int start_cnt;

  // 64 rises of 77 clocks match 2464 VCO rises of 2 clocks, so both dividers tick at the same rate, the reference a few clocks ahead
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      ref_cnt <= 0;
      start_cnt <= 0;
      o_reference_input <= 1'b0;
    end else if (i_fast) begin
      o_reference_input <= ~o_reference_input;
    end else if (start_cnt < REF_START) begin
      start_cnt <= start_cnt + 1;
    end else begin
      ref_cnt <= (ref_cnt == REF_PERIOD - 1) ? 0 : ref_cnt + 1;
      o_reference_input <= (ref_cnt < REF_PERIOD / 2);
    end
  end

  // A stalled oscillator sits low, which pushes the LO divider later
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_vco_input <= 1'b0;
    end else if (i_vco_stall) begin
      o_vco_input <= 1'b0;
    end else begin
      o_vco_input <= ~o_vco_input;
    end
  end
endmodule
`default_nettype wire

// ---- verilog/pll_divider_lock_control.sv ----
// Reference and LO dividers, phase detector, pump control, lock detector
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// - The VCO edges are divided by a fixed 2464 before the phase detector.
// - The reference ratio is one of nine, chosen by two three-state select pins.
// - First select low gives 36 with second open, 33 with it high, 48 with it low.
// - First select open gives 65 with second open, 63 with it high, 64 with it low.
// - First select high gives 35 with second open, 32 with it high, 49 with it low.
// - With the intended crystals both divider outputs run at 512 kHz in lock.
// - The three-state phase detector makes the pump source, sink or idle.
// - Loop control low gives 200 uA pump current, high gives 300 uA, lock valid.
// - Loop control at half supply switches the pump current off.
// - Loop control at half supply puts the LO divider output on the test pin.
// - Loop control open puts the reference divider output on the test pin.
// - Loop control open grounds the loop amplifier input node.
// - Lock is shown only after seven successive comparisons under 250 ns.
// - Loop control at half supply or open disables the lock detector.
module pll_divider_lock_control (
  input  wire logic                 i_clock,
  input  wire logic                 i_rst,
  input  wire logic                 i_reference_input,
  input  wire logic                 i_vco_input,
  input  wire pll_pkg::ref_select_t i_ref_select,
  input  wire pll_pkg::loop_level_t i_loop_control_pin,
  output var  pll_pkg::pump_t       o_pump_output,
  output logic                      o_loop_amp_node_ground,
  output logic                      o_test_monitor_output,
  output logic                      o_lock_indicator,
  output logic                      o_lock_indicator_oe
);

  logic                          ref_prev;
  logic                          vco_prev;
  logic                          ref_rise;
  logic                          vco_rise;
  logic [6:0]                    reference_ratio;
  logic [6:0]                    ref_cnt;
  logic [11:0]                   lo_cnt;
  logic                          ref_tick;
  logic                          lo_tick;
  pll_pkg::pfd_state_t           pfd_state;
  pll_pkg::pfd_state_t           next_pfd_state;
  logic [pll_pkg::ERR_W-1:0]     err_cnt;
  logic                          cmp_done;
  logic                          cmp_good;
  logic [2:0]                    good_cnt;
  logic                          locked;
  logic                          lock_enabled;
  pll_pkg::pump_current_t        next_current;

  assign ref_rise = i_reference_input & ~ref_prev;
  assign vco_rise = i_vco_input & ~vco_prev;
  assign lock_enabled = (i_loop_control_pin == pll_pkg::LOOP_GND) ||
                        (i_loop_control_pin == pll_pkg::LOOP_SUPPLY);

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      ref_prev <= 1'b0;
      vco_prev <= 1'b0;
    end else begin
      ref_prev <= i_reference_input;
      vco_prev <= i_vco_input;
    end
  end

  // Ratio table; the seven unused select codes fall back to the open/open entry
  always_comb begin
    unique case (i_ref_select)
      {pll_pkg::LEVEL_LOW, pll_pkg::LEVEL_OPEN}:  reference_ratio = pll_pkg::RATIO_36;
      {pll_pkg::LEVEL_LOW, pll_pkg::LEVEL_HIGH}:  reference_ratio = pll_pkg::RATIO_33;
      {pll_pkg::LEVEL_LOW, pll_pkg::LEVEL_LOW}:   reference_ratio = pll_pkg::RATIO_48;
      {pll_pkg::LEVEL_OPEN, pll_pkg::LEVEL_OPEN}: reference_ratio = pll_pkg::RATIO_65;
      {pll_pkg::LEVEL_OPEN, pll_pkg::LEVEL_HIGH}: reference_ratio = pll_pkg::RATIO_63;
      {pll_pkg::LEVEL_OPEN, pll_pkg::LEVEL_LOW}:  reference_ratio = pll_pkg::RATIO_64;
      {pll_pkg::LEVEL_HIGH, pll_pkg::LEVEL_OPEN}: reference_ratio = pll_pkg::RATIO_35;
      {pll_pkg::LEVEL_HIGH, pll_pkg::LEVEL_HIGH}: reference_ratio = pll_pkg::RATIO_32;
      {pll_pkg::LEVEL_HIGH, pll_pkg::LEVEL_LOW}:  reference_ratio = pll_pkg::RATIO_49;
      default:                                    reference_ratio = pll_pkg::RATIO_65;
    endcase
  end

  // Reference divider; a ratio change mid-count wraps at once rather than
  // running up to 127, so a step of one settles within a single period
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      ref_cnt  <= pll_pkg::REF_RESET;
      ref_tick <= 1'b0;
    end else begin
      ref_tick <= 1'b0;
      if (ref_rise) begin
        if (ref_cnt >= reference_ratio - 7'h01) begin
          ref_cnt  <= pll_pkg::REF_RESET;
          ref_tick <= 1'b1;
        end else begin
          ref_cnt <= ref_cnt + 7'h01;
        end
      end
    end
  end

  // Fixed LO divider
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      lo_cnt  <= pll_pkg::LO_RESET;
      lo_tick <= 1'b0;
    end else begin
      lo_tick <= 1'b0;
      if (vco_rise) begin
        if (lo_cnt == pll_pkg::LO_RATIO - 12'h001) begin
          lo_cnt  <= pll_pkg::LO_RESET;
          lo_tick <= 1'b1;
        end else begin
          lo_cnt <= lo_cnt + 12'h001;
        end
      end
    end
  end

  // Three-state detector: the leading divider opens a pump pulse,
  // the lagging one closes it; simultaneous edges are a zero-error compare
  always_comb begin
    next_pfd_state = pfd_state;
    cmp_done = 1'b0;
    unique case (pfd_state)
      pll_pkg::PFD_IDLE: begin
        if (ref_tick && lo_tick) begin
          cmp_done = 1'b1;
        end else if (ref_tick) begin
          next_pfd_state = pll_pkg::PFD_SOURCE;
        end else if (lo_tick) begin
          next_pfd_state = pll_pkg::PFD_SINK;
        end
      end
      pll_pkg::PFD_SOURCE: begin
        if (lo_tick) begin
          next_pfd_state = pll_pkg::PFD_IDLE;
          cmp_done = 1'b1;
        end
      end
      pll_pkg::PFD_SINK: begin
        if (ref_tick) begin
          next_pfd_state = pll_pkg::PFD_IDLE;
          cmp_done = 1'b1;
        end
      end
      default: begin
        next_pfd_state = pll_pkg::PFD_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      pfd_state <= pll_pkg::PFD_IDLE;
    end else begin
      pfd_state <= next_pfd_state;
    end
  end

  // Edge distance in clock cycles; saturates so a far-off loop never wraps
  // back into the window
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      err_cnt <= pll_pkg::ERR_RESET;
    end else if (next_pfd_state == pll_pkg::PFD_IDLE) begin
      err_cnt <= pll_pkg::ERR_RESET;
    end else if (pfd_state == pll_pkg::PFD_IDLE) begin
      err_cnt <= pll_pkg::ERR_FIRST;
    end else if (err_cnt != {pll_pkg::ERR_W{1'b1}}) begin
      err_cnt <= err_cnt + pll_pkg::ERR_FIRST;
    end
  end

  assign cmp_good = err_cnt < pll_pkg::WINDOW_COUNT;

  // Lock counter
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      good_cnt <= pll_pkg::GOOD_RESET;
      locked   <= 1'b0;
    end else if (!lock_enabled) begin
      good_cnt <= pll_pkg::GOOD_RESET;
      locked   <= 1'b0;
    end else if (cmp_done) begin
      if (!cmp_good) begin
        good_cnt <= pll_pkg::GOOD_RESET;
        locked   <= 1'b0;
      end else if (good_cnt != pll_pkg::LOCK_COUNT) begin
        good_cnt <= good_cnt + 3'h1;
        locked   <= good_cnt == pll_pkg::LOCK_COUNT - 3'h1;
      end
    end
  end

  // Pump current choice from the loop control pin
  always_comb begin
    unique case (i_loop_control_pin)
      pll_pkg::LOOP_GND:    next_current = pll_pkg::PUMP_200UA;
      pll_pkg::LOOP_SUPPLY: next_current = pll_pkg::PUMP_300UA;
      pll_pkg::LOOP_HALF:   next_current = pll_pkg::PUMP_OFF;
      pll_pkg::LOOP_OPEN:   next_current = pll_pkg::PUMP_OFF;
    endcase
  end

  // Registered pin drivers; the pump is taken from the next detector state, so it changes in the same cycle as pfd_state
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_pump_output <= '{source: 1'b0, sink: 1'b0, current: pll_pkg::PUMP_OFF};
    end else begin
      o_pump_output.current <= next_current;
      o_pump_output.source  <= (next_current != pll_pkg::PUMP_OFF) &&
                               (next_pfd_state == pll_pkg::PFD_SOURCE);
      o_pump_output.sink    <= (next_current != pll_pkg::PUMP_OFF) &&
                               (next_pfd_state == pll_pkg::PFD_SINK);
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_loop_amp_node_ground <= 1'b0;
    end else begin
      o_loop_amp_node_ground <= i_loop_control_pin == pll_pkg::LOOP_OPEN;
    end
  end

  // Test pin: square wave at the selected divider's output rate, low otherwise
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_test_monitor_output <= 1'b0;
    end else begin
      unique case (i_loop_control_pin)
        pll_pkg::LOOP_HALF:
          o_test_monitor_output <= lo_cnt < (pll_pkg::LO_RATIO >> 1);
        pll_pkg::LOOP_OPEN:
          o_test_monitor_output <= ref_cnt < (reference_ratio >> 1);
        pll_pkg::LOOP_GND, pll_pkg::LOOP_SUPPLY:
          o_test_monitor_output <= 1'b0;
      endcase
    end
  end

  // Open collector: released in lock so the external pull-up shows high
  assign o_lock_indicator    = 1'b0;
  assign o_lock_indicator_oe = ~locked;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  a_lo_fixed_ratio: assert property (
    lo_tick |-> $past(lo_cnt) == pll_pkg::LO_RATIO - 12'h001 && $past(vco_rise))
    else $error("LO divider ticked at wrong count");

  a_ratio_low_row: assert property (
    ref_tick && $past(i_ref_select) == {pll_pkg::LEVEL_LOW, pll_pkg::LEVEL_LOW}
    |-> $past(ref_cnt) >= pll_pkg::RATIO_48 - 7'h01)
    else $error("Reference ratio 48 not honoured");

  a_ratio_open_row: assert property (
    ref_rise && ref_cnt == pll_pkg::RATIO_64 - 7'h01
    && i_ref_select == {pll_pkg::LEVEL_OPEN, pll_pkg::LEVEL_OPEN} |=> !ref_tick)
    else $error("Ratio 65 ended one count early");

  a_ratio_high_row: assert property (
    ref_rise && ref_cnt == pll_pkg::RATIO_32 - 7'h01
    && i_ref_select == {pll_pkg::LEVEL_HIGH, pll_pkg::LEVEL_HIGH} |=> ref_tick)
    else $error("Ratio 32 did not end its period");

  a_pump_one_way: assert property (
    pfd_state == pll_pkg::PFD_SOURCE && !lo_tick && lock_enabled
    && $stable(i_loop_control_pin) |=> o_pump_output.source && !o_pump_output.sink)
    else $error("Pump not sourcing while reference leads");

  a_pump_current_sel: assert property (
    i_loop_control_pin == pll_pkg::LOOP_SUPPLY
    |=> o_pump_output.current == pll_pkg::PUMP_300UA)
    else $error("Pump current not 300 uA with control high");

  a_pump_off_half: assert property (
    i_loop_control_pin == pll_pkg::LOOP_HALF [*2]
    |-> !o_pump_output.source && !o_pump_output.sink)
    else $error("Pump active with control at half supply");

  a_amp_ground: assert property (
    $changed(i_loop_control_pin)
    |=> o_loop_amp_node_ground == ($past(i_loop_control_pin) == pll_pkg::LOOP_OPEN))
    else $error("Loop amplifier grounding wrong");

  a_lock_after_seven: assert property (
    $fell(o_lock_indicator_oe) |-> $past(good_cnt) == 3'h6 && $past(cmp_done && cmp_good))
    else $error("Lock shown before seven good comparisons");

  a_lock_disabled: assert property (
    !lock_enabled |=> good_cnt == pll_pkg::GOOD_RESET && o_lock_indicator_oe)
    else $error("Lock detector active while disabled");

  a_bad_compare: assert property (
    cmp_done && !cmp_good |=> o_lock_indicator_oe && good_cnt == pll_pkg::GOOD_RESET)
    else $error("Out of window comparison kept lock");

endmodule

`default_nettype wire
